// ---- rtl/temp_scaler_pkg.sv ----
package temp_scaler_pkg;

	// Register byte addresses on the bus.
	localparam logic [7:0] ADDR_GENERAL = 8'h00;
	localparam logic [7:0] ADDR_CH0_CFG = 8'h04;
	localparam logic [7:0] ADDR_CH1_CFG = 8'h08;
	localparam logic [7:0] ADDR_CH0_DATA = 8'h0c;
	localparam logic [7:0] ADDR_CH1_DATA = 8'h10;
	localparam logic [7:0] ADDR_FAULT = 8'h14;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
	localparam logic [7:0] ADDR_IRQ_EN = 8'h1c;
	localparam logic [7:0] ADDR_IRQ_CLR = 8'h20;

	// General register fields.
	localparam int GEN_RANGE_LSB = 0;
	localparam int GEN_FILT_LSB = 4;
	// Channel config fields.
	localparam int CFG_EN_BIT = 0;
	localparam int CFG_SCALED_BIT = 1;
	localparam int CFG_SCALE_LSB = 2;
	localparam int CFG_SMOOTH_BIT = 5;
	localparam int CFG_PERIODIC_BIT = 6;
	localparam int CFG_INTERVAL_LSB = 16;

	typedef enum logic [2:0] {
		RANGE_M40_90 = 3'h0,
		RANGE_0_250 = 3'h1,
		RANGE_0_400 = 3'h2,
		RANGE_0_850 = 3'h3,
		RANGE_M200_200 = 3'h4
	} range_t;

	typedef enum logic [1:0] {
		FILT_50HZ = 2'h0,
		FILT_60HZ = 2'h1,
		FILT_250HZ = 2'h2,
		FILT_500HZ = 2'h3
	} filt_t;

	typedef enum logic [2:0] {
		SCALE_RAW = 3'h0,
		SCALE_C1 = 3'h1,
		SCALE_C01 = 3'h2,
		SCALE_F1 = 3'h3,
		SCALE_F01 = 3'h4
	} scale_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CONVERT = 2'b01,
		ST_WAIT = 2'b10
	} acq_state_t;

	// Times.
	localparam int CLK_HZ = 10_000_000;
	localparam int CYC_MS_50 = 350;
	localparam int CYC_MS_60 = 370;
	localparam int CYC_MS_250 = 320;
	localparam int CYC_MS_500 = 160;
	localparam int SCAN_MIN_MS = 200;
	localparam int TICKS_PER_MS = CLK_HZ / 1000;
	localparam logic [15:0] MS_TICKS = 16'(TICKS_PER_MS);
	localparam int SMOOTH_SHIFT = 3;

	// Reset values.
	localparam logic [15:0] SCAN_RESET = 16'(SCAN_MIN_MS);
	localparam logic [11:0] ADC_MAX = 12'hfff;

	// Interrupt event bits, per channel: new data, fault.
	localparam int IRQ_W = 4;

	typedef struct packed {
		logic enable;
		logic scaled;
		scale_t scale;
		logic smooth;
		logic periodic;
		logic [15:0] interval_ms;
	} ch_cfg_t;

	typedef struct packed {
		logic short_circ;
		logic wire_break;
		logic below;
		logic above;
	} fault_t;

	typedef struct packed {
		acq_state_t state;
		logic [15:0] tick;
		logic [15:0] ms_cnt;
		logic [11:0] smooth;
		logic primed;
		logic signed [31:0] result;
		fault_t fault;
	} chan_t;

endpackage

// ---- rtl/dual_temp_scaler.sv ----
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - One measuring range setting shared by both channels; resets to -40..+90 C.
// - Converter filter frequency selectable 50/60/250/500 Hz, 50 Hz after reset.
// - New value per channel within 350/370/320/160 ms depending on filter.
// - Converter filter setting acts independent of scan interval.
// - Each channel enabled separately, both on by default, no cross effect.
// - Enabled channel without sensor reports wire break fault.
// - Output, scaling, smoothing, sampling settings accepted only while channel enabled.
// - Raw mode gives unsigned 0..4095 conversion result.
// - Scaled mode gives signed fixed-point result in one of four stages.
// - Scaling defaults to raw 12 bit; else C or F at 1 or 0.1 degree.
// - -40..90 C range gives -400..900 at 0.1 C and -40..194 at 1 F.
// - Scaled result is temperature in chosen unit divided by resolution step.
// - Optional per-channel first-order smoothing, off by default.
// - Periodic sampling off: conversions back to back.
// - Periodic sampling on: equal intervals, interval default and minimum 200 ms.
// - Per-channel short, break, below, above flags; serious faults latch.
module dual_temp_scaler (
	// Clock and reset
	input wire logic MCLK_IN,
	input wire logic RESET_IN,
	// Wishbone slave
	input wire logic WB_CYC_IN,
	input wire logic WB_STB_IN,
	input wire logic WB_WE_IN,
	input wire logic [7:0] WB_ADR_IN,
	input wire logic [3:0] WB_SEL_IN,
	input wire logic [31:0] WB_DAT_IN,
	output logic [31:0] WB_DAT_OUT,
	output logic WB_ACK_OUT,
	// Converter front end, one per channel
	output logic [1:0] CONV_START_OUT,
	output logic [1:0] CONV_FILT_OUT,
	input wire logic [1:0] CONV_DONE_IN,
	input wire logic [11:0] CONV_DATA0_IN,
	input wire logic [11:0] CONV_DATA1_IN,
	input wire logic [1:0] SENSOR_OPEN_IN,
	input wire logic [1:0] SENSOR_SHORT_IN,
	// Interrupt
	output logic IRQ_OUT
);
	import temp_scaler_pkg::*;

	typedef struct packed {
		range_t range;
		filt_t filt;
		ch_cfg_t [1:0] cfg;
		chan_t [1:0] ch;
		logic [IRQ_W-1:0] irq_stat;
		logic [IRQ_W-1:0] irq_en;
		logic ack;
		logic [31:0] rdata;
	} state_t;

	state_t s_r;
	state_t s_nxt;

	// Convert the 12-bit code to tenths of a degree Celsius across the range.
	function automatic logic signed [31:0] to_tenth_c(input range_t r, input logic [11:0] code);
		logic signed [31:0] lo;
		logic signed [31:0] span;
		lo = 32'sd0;
		span = 32'sd1300;
		case (r)
			RANGE_M40_90: begin
				lo = -32'sd400;
				span = 32'sd1300;
			end
			RANGE_0_250: begin
				lo = 32'sd0;
				span = 32'sd2500;
			end
			RANGE_0_400: begin
				lo = 32'sd0;
				span = 32'sd4000;
			end
			RANGE_0_850: begin
				lo = 32'sd0;
				span = 32'sd8500;
			end
			default: begin
				lo = -32'sd2000;
				span = 32'sd4000;
			end
		endcase
		to_tenth_c = lo + (span * $signed({20'h00000, code})) / $signed({20'h00000, ADC_MAX});
	endfunction

	// Scale tenths of C into the selected unit and step; division truncates toward zero.
	function automatic logic signed [31:0] scale_val(input scale_t sc, input logic signed [31:0] tc);
		logic signed [31:0] tf;
		tf = (tc * 32'sd9) / 32'sd5 + 32'sd320;
		case (sc)
			SCALE_C1: scale_val = tc / 32'sd10;
			SCALE_C01: scale_val = tc;
			SCALE_F1: scale_val = tf / 32'sd10;
			SCALE_F01: scale_val = tf;
			default: scale_val = tc;
		endcase
	endfunction

	function automatic logic [15:0] cycle_ms(input filt_t f);
		case (f)
			FILT_50HZ: cycle_ms = 16'(CYC_MS_50);
			FILT_60HZ: cycle_ms = 16'(CYC_MS_60);
			FILT_250HZ: cycle_ms = 16'(CYC_MS_250);
			default: cycle_ms = 16'(CYC_MS_500);
		endcase
	endfunction

	// Each channel's config register sits at its own address.
	function automatic logic cfg_hit(input logic [7:0] a, input int i);
		if (i == 0) begin
			cfg_hit = (a == ADDR_CH0_CFG);
		end else begin
			cfg_hit = (a == ADDR_CH1_CFG);
		end
	endfunction

	function automatic logic [31:0] cfg_word(input ch_cfg_t c);
		cfg_word = {c.interval_ms, 9'h000, c.periodic, c.smooth, c.scale, c.scaled, c.enable};
	endfunction

	// Codes above the last scaling stage fall back to raw output.
	function automatic scale_t legal_scale(input logic [2:0] code);
		if (code > 3'(SCALE_F01)) begin
			legal_scale = SCALE_RAW;
		end else begin
			legal_scale = scale_t'(code);
		end
	endfunction

	// Intervals below the minimum are raised to it rather than refused.
	function automatic logic [15:0] clamp_interval(input logic [15:0] ms);
		clamp_interval = (ms < SCAN_RESET) ? SCAN_RESET : ms;
	endfunction

	// First-order low pass: seven parts old value, one part new sample.
	function automatic logic [11:0] next_smooth(input logic [11:0] y, input logic [11:0] x);
		logic [15:0] acc;
		acc = {4'h0, y} * 16'h0007 + {4'h0, x};
		next_smooth = 12'(acc >> SMOOTH_SHIFT);
	endfunction

	// Periodic channels wait out their interval; free-running ones get the cycle budget.
	function automatic logic [15:0] period_for(input ch_cfg_t c, input filt_t f);
		if (c.periodic) begin
			period_for = c.interval_ms;
		end else begin
			period_for = cycle_ms(f);
		end
	endfunction

	// A fault counts as new when a serious flag goes from clear to set.
	function automatic logic new_serious(input fault_t was, input fault_t now);
		new_serious = (now.short_circ & ~was.short_circ) | (now.wire_break & ~was.wire_break);
	endfunction

	// Sensor status pins come from outside: three stages, change once stages two and three agree.
	logic [1:0] open_s1, open_s2, open_s3, open_q;
	logic [1:0] short_s1, short_s2, short_s3, short_q;
	logic [1:0] done_s1, done_s2, done_s3, done_q, done_prev;
	always_ff @(posedge MCLK_IN) begin
		open_s1 <= SENSOR_OPEN_IN;
		open_s2 <= open_s1;
		open_s3 <= open_s2;
		short_s1 <= SENSOR_SHORT_IN;
		short_s2 <= short_s1;
		short_s3 <= short_s2;
		done_s1 <= CONV_DONE_IN;
		done_s2 <= done_s1;
		done_s3 <= done_s2;
		if (RESET_IN) begin
			open_q <= 2'h0;
			short_q <= 2'h0;
			done_q <= 2'h0;
			done_prev <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (open_s2[i] == open_s3[i]) open_q[i] <= open_s3[i];
				if (short_s2[i] == short_s3[i]) short_q[i] <= short_s3[i];
				if (done_s2[i] == done_s3[i]) done_q[i] <= done_s3[i];
			end
			done_prev <= done_q;
		end
	end

	// Data is held stable by the converter while done is high, so it is read directly.
	logic [1:0][11:0] conv_data;
	assign conv_data[0] = CONV_DATA0_IN;
	assign conv_data[1] = CONV_DATA1_IN;

	logic bus_req;
	logic bus_wr;
	assign bus_req = WB_CYC_IN && WB_STB_IN && !s_r.ack;
	assign bus_wr = bus_req && WB_WE_IN;

	always_comb begin
		logic [1:0] done_rise;
		logic [IRQ_W-1:0] ev;
		logic signed [31:0] tc;
		logic [11:0] filt_code;
		logic [15:0] period_ms;
		logic [31:0] wd;
		done_rise = done_q & ~done_prev;
		ev = '0;
		tc = 32'sd0;
		filt_code = 12'h000;
		period_ms = 16'h0000;
		wd = WB_DAT_IN;
		s_nxt = s_r;
		s_nxt.ack = bus_req;

		// General register writes steer range and filter for both channels.
		if (bus_wr && WB_ADR_IN == ADDR_GENERAL && WB_SEL_IN[0]) begin
			s_nxt.range = range_t'(wd[GEN_RANGE_LSB +: 3]);
			s_nxt.filt = filt_t'(wd[GEN_FILT_LSB +: 2]);
		end

		for (int i = 0; i < 2; i++) begin
			// Channel config: enable always writable, the rest only while enabled.
			if (bus_wr && cfg_hit(WB_ADR_IN, i)) begin
				if (WB_SEL_IN[0]) s_nxt.cfg[i].enable = wd[CFG_EN_BIT];
				if (s_r.cfg[i].enable) begin
					if (WB_SEL_IN[0]) begin
						s_nxt.cfg[i].scaled = wd[CFG_SCALED_BIT];
						s_nxt.cfg[i].scale = legal_scale(wd[CFG_SCALE_LSB +: 3]);
						s_nxt.cfg[i].smooth = wd[CFG_SMOOTH_BIT];
						s_nxt.cfg[i].periodic = wd[CFG_PERIODIC_BIT];
					end
					if (WB_SEL_IN[3:2] == 2'b11) begin
						s_nxt.cfg[i].interval_ms = clamp_interval(wd[CFG_INTERVAL_LSB +: 16]);
					end
				end
			end

			// Live fault flags; serious faults (short, break) stay latched until read-clear.
			s_nxt.ch[i].fault.short_circ = s_r.ch[i].fault.short_circ |
				(s_r.cfg[i].enable & short_q[i]);
			s_nxt.ch[i].fault.wire_break = s_r.ch[i].fault.wire_break |
				(s_r.cfg[i].enable & open_q[i]);
			if (new_serious(s_r.ch[i].fault, s_nxt.ch[i].fault)) begin
				ev[2 * i + 1] = 1'b1;
			end

			// Millisecond time base for cycle budget and scan interval.
			if (s_r.ch[i].tick == MS_TICKS - 16'h0001) begin
				s_nxt.ch[i].tick = 16'h0000;
				s_nxt.ch[i].ms_cnt = s_r.ch[i].ms_cnt + 16'h0001;
			end else begin
				s_nxt.ch[i].tick = s_r.ch[i].tick + 16'h0001;
			end
			period_ms = period_for(s_r.cfg[i], s_r.filt);

			case (s_r.ch[i].state)
				ST_IDLE: begin
					s_nxt.ch[i].tick = 16'h0000;
					s_nxt.ch[i].ms_cnt = 16'h0000;
					if (s_r.cfg[i].enable) s_nxt.ch[i].state = ST_CONVERT;
				end
				ST_CONVERT: begin
					if (!s_r.cfg[i].enable) begin
						s_nxt.ch[i].state = ST_IDLE;
					end else if (done_rise[i]) begin
						// Converter filter, then smoothing, then scaling.
						filt_code = conv_data[i];
						if (s_r.cfg[i].smooth && s_r.ch[i].primed) begin
							filt_code = next_smooth(s_r.ch[i].smooth, conv_data[i]);
						end
						s_nxt.ch[i].smooth = filt_code;
						s_nxt.ch[i].primed = 1'b1;
						tc = to_tenth_c(s_r.range, filt_code);
						if (s_r.cfg[i].scaled && s_r.cfg[i].scale != SCALE_RAW) begin
							s_nxt.ch[i].result = scale_val(s_r.cfg[i].scale, tc);
						end else begin
							s_nxt.ch[i].result = {20'h00000, filt_code};
						end
						s_nxt.ch[i].fault.below = (filt_code == 12'h000);
						s_nxt.ch[i].fault.above = (filt_code == ADC_MAX);
						ev[2 * i] = 1'b1;
						s_nxt.ch[i].state = s_r.cfg[i].periodic ? ST_WAIT : ST_CONVERT;
						// Free-running time is measured per result; periodic time from the start.
						if (!s_r.cfg[i].periodic) begin
							s_nxt.ch[i].tick = 16'h0000;
							s_nxt.ch[i].ms_cnt = 16'h0000;
						end
					end else if (s_r.ch[i].ms_cnt >= cycle_ms(s_r.filt)) begin
						// No answer within the cycle budget: drop start for a cycle to rearm
						// the converter, so a stuck conversion cannot stall the channel for good.
						s_nxt.ch[i].state = ST_IDLE;
					end
				end
				default: begin
					// Periodic mode: next conversion starts when the interval elapses.
					if (!s_r.cfg[i].enable) begin
						s_nxt.ch[i].state = ST_IDLE;
					end else if (s_r.ch[i].ms_cnt >= period_ms) begin
						s_nxt.ch[i].ms_cnt = 16'h0000;
						s_nxt.ch[i].tick = 16'h0000;
						s_nxt.ch[i].state = ST_CONVERT;
					end
				end
			endcase
		end

		// Read mux; reading the fault register clears latched faults not currently present.
		s_nxt.rdata = 32'h00000000;
		if (bus_req && !WB_WE_IN) begin
			if (WB_ADR_IN == ADDR_GENERAL) begin
				s_nxt.rdata = {26'h0, s_r.filt, 1'b0, s_r.range};
			end else if (WB_ADR_IN == ADDR_CH0_CFG || WB_ADR_IN == ADDR_CH1_CFG) begin
				for (int i = 0; i < 2; i++) begin
					if (cfg_hit(WB_ADR_IN, i)) begin
						s_nxt.rdata = cfg_word(s_r.cfg[i]);
					end
				end
			end else if (WB_ADR_IN == ADDR_CH0_DATA) begin
				s_nxt.rdata = s_r.ch[0].result;
			end else if (WB_ADR_IN == ADDR_CH1_DATA) begin
				s_nxt.rdata = s_r.ch[1].result;
			end else if (WB_ADR_IN == ADDR_FAULT) begin
				s_nxt.rdata = {24'h000000, s_r.ch[1].fault, s_r.ch[0].fault};
				for (int i = 0; i < 2; i++) begin
					s_nxt.ch[i].fault.short_circ = short_q[i] & s_r.cfg[i].enable;
					s_nxt.ch[i].fault.wire_break = open_q[i] & s_r.cfg[i].enable;
				end
			end else if (WB_ADR_IN == ADDR_IRQ_STAT) begin
				s_nxt.rdata = {28'h0000000, s_r.irq_stat};
			end else if (WB_ADR_IN == ADDR_IRQ_EN) begin
				s_nxt.rdata = {28'h0000000, s_r.irq_en};
			end
		end

		// Interrupts: write-one-to-clear, a new event in the same cycle wins.
		if (bus_wr && WB_ADR_IN == ADDR_IRQ_EN && WB_SEL_IN[0]) s_nxt.irq_en = wd[IRQ_W-1:0];
		if (bus_wr && WB_ADR_IN == ADDR_IRQ_CLR && WB_SEL_IN[0]) begin
			s_nxt.irq_stat = s_r.irq_stat & ~wd[IRQ_W-1:0];
		end
		s_nxt.irq_stat = s_nxt.irq_stat | ev;
	end

	always_ff @(posedge MCLK_IN) begin
		if (RESET_IN) begin
			s_r <= '0;
			s_r.range <= RANGE_M40_90;
			s_r.filt <= FILT_50HZ;
			for (int i = 0; i < 2; i++) begin
				s_r.cfg[i].enable <= 1'b1;
				s_r.cfg[i].scale <= SCALE_RAW;
				s_r.cfg[i].interval_ms <= SCAN_RESET;
				s_r.ch[i].state <= ST_IDLE;
			end
		end else begin
			s_r <= s_nxt;
		end
	end

	// The converter filter code follows the shared setting alone, whatever the scan mode.
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			CONV_START_OUT[i] = (s_r.ch[i].state == ST_CONVERT);
			CONV_FILT_OUT[i] = 1'b0;
		end
		CONV_FILT_OUT = s_r.filt;
	end

	assign WB_ACK_OUT = s_r.ack;
	assign WB_DAT_OUT = s_r.rdata;
	assign IRQ_OUT = |(s_r.irq_stat & s_r.irq_en);

endmodule

`default_nettype wire

// ---- verification/dual_temp_scaler_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module dual_temp_scaler_asserts (
	// Clock and reset
	input wire logic MCLK_IN,
	input wire logic RESET_IN,
	// Bus
	input wire logic WB_CYC_IN,
	input wire logic WB_STB_IN,
	input wire logic WB_WE_IN,
	input wire logic [7:0] WB_ADR_IN,
	input wire logic WB_ACK_OUT,
	// Converter and interrupt
	input wire logic [1:0] CONV_START_OUT,
	input wire logic [1:0] CONV_FILT_OUT,
	input wire logic [1:0] CONV_DONE_IN,
	input wire logic IRQ_OUT
);
	import temp_scaler_pkg::*;
	wire logic req = WB_CYC_IN && WB_STB_IN;
	wire logic wgen = req && WB_WE_IN && WB_ADR_IN == ADDR_GENERAL;
	default clocking cb @(posedge MCLK_IN);
	endclocking
	default disable iff (RESET_IN);
	AST_ACK_LAT: assert property (req && !WB_ACK_OUT |=> WB_ACK_OUT)
		else $error("ack late");
	AST_ACK_PULSE: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
		else $error("ack too long");
	AST_ACK_CAUSE: assert property ($rose(WB_ACK_OUT) |-> $past(req))
		else $error("ack without request");
	AST_FILT_RST: assert property ($fell(RESET_IN) |-> CONV_FILT_OUT == 2'h0)
		else $error("filter not 50 Hz after reset");
	AST_START_RST: assert property ($fell(RESET_IN) |-> ##[1:2] CONV_START_OUT == 2'h3)
		else $error("channels not both running");
	AST_IRQ_RST: assert property ($fell(RESET_IN) |-> !IRQ_OUT)
		else $error("irq after reset");
	// A filter change must come from a general write, never from sampling activity.
	AST_FILT_CHANGE: assert property (!$stable(CONV_FILT_OUT) |-> $past(wgen) || $past(wgen, 2))
		else $error("filter moved without write");
	AST_FREE_RUN: assert property ($rose(CONV_START_OUT[0]) && !req && !CONV_DONE_IN[0]
		|=> CONV_START_OUT[0])
		else $error("start dropped early");
	CVR_WRITE: cover property (WB_ACK_OUT && $past(WB_WE_IN));
	CVR_IRQ: cover property ($rose(IRQ_OUT));
	CVR_WAIT: cover property ($fell(CONV_START_OUT[0]));
endmodule
bind dual_temp_scaler dual_temp_scaler_asserts i_dual_temp_scaler_asserts (
	.MCLK_IN(MCLK_IN),
	.RESET_IN(RESET_IN),
	.WB_CYC_IN(WB_CYC_IN),
	.WB_STB_IN(WB_STB_IN),
	.WB_WE_IN(WB_WE_IN),
	.WB_ADR_IN(WB_ADR_IN),
	.WB_ACK_OUT(WB_ACK_OUT),
	.CONV_START_OUT(CONV_START_OUT),
	.CONV_FILT_OUT(CONV_FILT_OUT),
	.CONV_DONE_IN(CONV_DONE_IN),
	.IRQ_OUT(IRQ_OUT)
);
`default_nettype wire

// ---- verification/conv_partner_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module conv_partner_model (
	// Clock and pacing
	input wire logic clk,
	input wire logic slow,
	// Converter link
	input wire logic [1:0] start,
	input wire logic [23:0] code,
	output logic [1:0] done,
	output logic [23:0] data
);
	logic [7:0] lat;
	assign lat = slow ? 8'h30 : 8'h06;
	for (genvar g = 0; g < 2; g++) begin : g_ch
		logic [7:0] cnt = 8'h00;
		logic dn = 1'b0;
		logic [11:0] val = 12'h000;
		assign done[g] = dn;
		assign data[g * 12 +: 12] = val;
		always_ff @(posedge clk) begin
			if (cnt == 8'h00) begin
				cnt <= {7'h0, start[g]};
			end else begin
				cnt <= (cnt == lat + 8'h08) ? 8'h00 : cnt + 8'h01;
			end
			if (cnt == lat) begin
				dn <= 1'b1;
				val <= code[g * 12 +: 12];
			end else if (cnt == lat + 8'h08) begin
				// Data is not held once done falls, so a late read shows garbage.
				dn <= 1'b0;
				val <= ~val;
			end
		end
	end
endmodule
`default_nettype wire

// ---- verification/dual_temp_scaler_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin num_errors++; \
	$display("FAIL %0t got %h want %h", $time, a, e); end end
module dual_temp_scaler_bench;
	import temp_scaler_pkg::*;
	typedef struct packed {
		scale_t sc;
		logic [11:0] code;
		logic [31:0] exp;
	} row_t;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic req = 1'b0;
	logic we = 1'b0;
	logic slow = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wd = 32'h0;
	logic [31:0] rd, q, cfg;
	logic [1:0] start, filt, done, sopen = 2'h0, sshort = 2'h0;
	logic [23:0] code = 24'h0;
	logic [23:0] data;
	logic ack, irq;
	int num_errors = 0;
	int num_checks = 0;
	int n;
	row_t rows [10] = '{'{SCALE_RAW, 12'h000, 32'h0}, '{SCALE_RAW, 12'hfff, 32'hfff},
		'{SCALE_C01, 12'h000, 32'hfffffe70}, '{SCALE_C01, 12'hfff, 32'h384},
		'{SCALE_F1, 12'h000, 32'hffffffd8}, '{SCALE_F1, 12'hfff, 32'hc2},
		'{SCALE_F01, 12'hfff, 32'h794}, '{SCALE_C1, 12'h800, 32'h19},
		'{SCALE_F01, 12'h800, 32'h302}, '{SCALE_F1, 12'h800, 32'h4d}};
	always #50 clk = ~clk;
	dual_temp_scaler i_dual_temp_scaler (.MCLK_IN(clk), .RESET_IN(rst), .WB_CYC_IN(req),
		.WB_STB_IN(req), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'hf), .WB_DAT_IN(wd),
		.WB_DAT_OUT(rd), .WB_ACK_OUT(ack), .CONV_START_OUT(start), .CONV_FILT_OUT(filt),
		.CONV_DONE_IN(done), .CONV_DATA0_IN(data[11:0]), .CONV_DATA1_IN(data[23:12]),
		.SENSOR_OPEN_IN(sopen), .SENSOR_SHORT_IN(sshort), .IRQ_OUT(irq));
	conv_partner_model i_conv_partner_model (.clk(clk), .slow(slow), .start(start),
		.code(code), .done(done), .data(data));
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk);
		req <= 1'b1;
		we <= w;
		adr <= a;
		wd <= d;
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'b1 && k < 50);
		q = rd;
		req <= 1'b0;
		if (k >= 50) begin
			num_errors++;
			$display("FAIL %0t bus timeout", $time);
		end
	endtask
	task automatic wirq();
		int k;
		k = 0;
		while (irq !== 1'b1 && k < 3000) begin
			@(posedge clk);
			k++;
		end
		if (k >= 3000) begin
			num_errors++;
			$display("FAIL %0t no interrupt", $time);
		end
	endtask
	// Code changes only after a result, so the next result is exactly one new sample.
	task automatic sample(input logic [3:0] m, input logic [23:0] c);
		wb(1'b1, ADDR_IRQ_EN, {28'h0, m});
		wb(1'b1, ADDR_IRQ_CLR, {28'h0, m});
		repeat (2) @(posedge clk);
		wirq();
		code <= c;
		wb(1'b1, ADDR_IRQ_CLR, {28'h0, m});
		repeat (2) @(posedge clk);
		wirq();
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		#6_000_000;
		num_errors++;
		$display("FAIL %0t watchdog", $time);
		wrap_up();
	end
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		`CHK(filt, 2'h0)
		wb(1'b0, ADDR_GENERAL, 32'h0);
		`CHK(q, 32'h0)
		wb(1'b0, ADDR_CH0_CFG, 32'h0);
		`CHK(q, 32'h00c80001)
		wb(1'b0, 8'hfc, 32'h0);
		`CHK(q, 32'h0)
		$display("reset test done");
		foreach (rows[i]) begin
			cfg = {16'h00c8, 11'h0, rows[i].sc, rows[i].sc != SCALE_RAW, 1'b1};
			wb(1'b1, ADDR_CH0_CFG, cfg);
			sample(4'h1, {12'h123, rows[i].code});
			wb(1'b0, ADDR_CH0_DATA, 32'h0);
			`CHK(q, rows[i].exp)
		end
		$display("scaling test done");
		for (int f = 0; f < 5; f++) begin
			wb(1'b1, ADDR_GENERAL, {26'h0, 2'(f), 4'h0});
			@(posedge clk);
			`CHK(filt, 2'(f))
		end
		wb(1'b1, ADDR_CH1_CFG, 32'h0);
		wb(1'b1, ADDR_CH1_CFG, 32'h00320016);
		wb(1'b0, ADDR_CH1_CFG, 32'h0);
		`CHK(q, 32'h00c80000)
		wb(1'b0, ADDR_CH0_CFG, 32'h0);
		`CHK(q, 32'h00c8000f)
		wb(1'b1, ADDR_CH1_CFG, 32'h00c80001);
		sample(4'h4, {12'h123, 12'h800});
		wb(1'b0, ADDR_CH1_DATA, 32'h0);
		`CHK(q, 32'h123)
		wb(1'b1, ADDR_IRQ_EN, 32'h0);
		repeat (100) @(posedge clk);
		`CHK(irq, 1'b0)
		wb(1'b0, ADDR_IRQ_STAT, 32'h0);
		`CHK(q[0], 1'b1)
		$display("channel test done");
		slow <= 1'b1;
		wb(1'b1, ADDR_CH0_CFG, 32'h00c80001);
		sample(4'h1, {12'h123, 12'hfff});
		wb(1'b1, ADDR_CH0_CFG, 32'h00c80021);
		sample(4'h1, {12'h123, 12'hfff});
		sample(4'h1, {12'h123, 12'h000});
		wb(1'b0, ADDR_CH0_DATA, 32'h0);
		`CHK(q, 32'hdff)
		slow <= 1'b0;
		sopen <= 2'h1;
		repeat (10) @(posedge clk);
		wb(1'b0, ADDR_FAULT, 32'h0);
		`CHK(q[2], 1'b1)
		wb(1'b0, ADDR_IRQ_STAT, 32'h0);
		`CHK(q[1], 1'b1)
		sopen <= 2'h0;
		sshort <= 2'h1;
		repeat (10) @(posedge clk);
		wb(1'b0, ADDR_FAULT, 32'h0);
		`CHK(q[3:2], 2'h3)
		sshort <= 2'h0;
		repeat (10) @(posedge clk);
		wb(1'b0, ADDR_FAULT, 32'h0);
		wb(1'b0, ADDR_FAULT, 32'h0);
		`CHK(q[3:2], 2'h0)
		$display("fault test done");
		wb(1'b1, ADDR_CH0_CFG, 32'h00c80041);
		wb(1'b1, ADDR_IRQ_EN, 32'h1);
		wb(1'b1, ADDR_IRQ_CLR, 32'h1);
		repeat (2) @(posedge clk);
		wirq();
		repeat (20) @(posedge clk);
		n = 0;
		repeat (300) begin
			@(posedge clk);
			if (start[0] !== 1'b0) n++;
		end
		`CHK(n, 0)
		$display("periodic test done");
		wrap_up();
	end
endmodule
`default_nettype wire
